// ---- serial_defs.svh ----
// Offsets, field positions, reset values and timing counts of the serial unit
// Summary of operation
// R1 - Characters are seven or eight data bits, both directions, chosen by software.
// R2 - Bit rates up to 625 kbps are reachable from the system clock.
// R3 - An eight-bit programmable divider sets the bit time.
// R4 - Transmitter and receiver run independently, full duplex.
// R5 - Characters shift out and in MSB first or LSB first.
// R6 - Inversion flips only the transmit pin; the receive input is never inverted.
// R7 - Hardware sends a break of 13 to 20 low bits, set by a 3-bit field.
// R8 - Eleven or more low bits is a valid break and pulses; shorter is an error.
// R9 - During break reception no error checks, no buffer load, shifter stays FFH.
// R10 - The transmit-done pulse follows every character and every sent break.
// R11 - A stopped clock freezes all state; software re-enables with cleared enables.
// R12 - Software sets power enable before transmit or receive enable.
// R13 - Enables are resynchronised to the base clock; re-set after two base clocks.
// R14 - Software waits one base clock after transmit enable before the first write.
// R15 - Back-to-back characters get two extra base clocks between stop and start.
// R16 - Software does not use back-to-back transmission on a LIN bus.
// R17 - Software sends a wakeup as one character of 80H in eight-bit mode.
// R18 - Software spaces the LIN frame fields itself.
// R19 - Software measures the sync field, disables the unit and reprograms the divider.
// R20 - Software reinitialises and re-arms break reception after the checksum.
// R21 - Two route bits copy the receive input to interrupt and capture outputs.
// R22 - Seven-bit data: LSB-first in bits 0-6, MSB-first in bits 1-7, other bit 0.
// R23 - On overrun the receive buffer keeps its old character.
// R24 - A write to the transmit buffer starts transmission of that character.
// R25 - Clearing power enable stops the base clock and resets the serial logic.
// R26 - Frames have one low start and a high stop; receiver resyncs on start.
`ifndef SERIAL_DEFS_SVH
`define SERIAL_DEFS_SVH

// Register byte offsets
`define OFS_MODE 8'h00
`define OFS_CTRL 8'h04
`define OFS_BAUD 8'h08
`define OFS_CLKSEL 8'h0C
`define OFS_TXBUF 8'h10
`define OFS_RXBUF 8'h14
`define OFS_STATUS 8'h18
`define OFS_ROUTE 8'h1C

// Mode register fields
`define MODE_POWER 7
`define MODE_TXEN 6
`define MODE_RXEN 5
`define MODE_LEN8 2
// Control register fields
`define CTRL_BRK_ARM 7
`define CTRL_BRK_SEND 6
`define CTRL_BRK_LEN_HI 4
`define CTRL_BRK_LEN_LO 2
`define CTRL_MSB_FIRST 1
`define CTRL_TX_INV 0
// Status register fields
`define ST_TX_BUSY 0
`define ST_TXBUF_FULL 1
`define ST_RX_VALID 2
`define ST_BRK_OK 4
`define ST_BRK_ERR 5
`define ST_OVERRUN 6
`define ST_FRAMING 7
// Route register fields
`define ROUTE_IRQ 0
`define ROUTE_TIMER 1

// Reset values
`define RST_MODE 8'h04
`define RST_BAUD 8'hFF
`define RST_BUF 8'hFF

// Timing
`define CLK_MHZ 200
`define MAX_RATE_KBPS 625
`define MIN_BIT_CLKS ((`CLK_MHZ * 1000) / `MAX_RATE_KBPS)
`define BRK_BASE_BITS 5'h0D
`define BRK_VALID_BITS 5'h0B
`define GAP_TICKS 8'h02

`endif

// ---- serial_pkg.sv ----
// Types shared by the serial unit
package serial_pkg;

    typedef enum logic [2:0] {
        TX_IDLE, TX_BREAK, TX_START, TX_DATA, TX_STOP, TX_GAP
    } tx_state_t;

    typedef enum logic [1:0] {
        RX_IDLE, RX_START, RX_DATA, RX_STOP
    } rx_state_t;

    typedef struct packed {
        logic [7:0] mode;
        logic [7:0] ctrl;
        logic [7:0] baud;
        logic [2:0] clksel;
        logic [1:0] route;
        logic [7:0] txbuf;
        logic [7:0] rxbuf;
        logic txbuf_full;
        logic rx_valid;
        logic ovr;
        logic fe;
        logic brk_ok;
        logic brk_err;
        logic tx_en_s;
        logic rx_en_s;
        logic [7:0] pre_cnt;
        logic base_tick;
        tx_state_t tx_st;
        logic [7:0] tx_tick;
        logic [4:0] tx_bits;
        logic [7:0] tx_sh;
        logic tx_line;
        logic tx_pin;
        logic tx_done;
        rx_state_t rx_st;
        logic [7:0] rx_tick;
        logic [4:0] rx_bits;
        logic [7:0] rx_sh;
        logic [2:0] rx_sync;
        logic rx_filt;
        logic rx_done;
        logic brk_pulse;
        logic [7:0] addr;
        logic wr_pend;
        logic [31:0] rdata;
    } state_t;

endpackage

// ---- lin_capable_async_serial.sv ----
// Asynchronous serial unit with LIN break support and an AHB-Lite slave
`timescale 1ns/1ps
`include "serial_defs.svh"

module lin_capable_async_serial (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Clock supply stopped by the system
    input wire logic clock_stop,
    // Serial line
    input wire logic serial_rx_pin,
    output logic serial_tx_pin,
    // Event pulses
    output logic tx_done_interrupt,
    output logic rx_done_interrupt,
    output logic break_interrupt,
    // Receive input routed to other peripherals
    output logic external_edge_interrupt,
    output logic timer_capture_input
);

    logic [1:0] rst_sync_q;
    logic rst_i;
    serial_pkg::state_t st_q;
    serial_pkg::state_t st_d;
    logic acc;
    logic [4:0] last_bit;
    logic [4:0] brk_last;
    logic tx_bit_end;
    logic rx_full_end;

    function automatic logic [7:0] rd_mux(input serial_pkg::state_t s,
                                          input logic [7:0] a);
        logic [7:0] v;
        v = 8'h00;
        if (a == `OFS_MODE) begin
            v = s.mode;
        end else if (a == `OFS_CTRL) begin
            v = s.ctrl;
        end else if (a == `OFS_BAUD) begin
            v = s.baud;
        end else if (a == `OFS_CLKSEL) begin
            v = {5'h00, s.clksel};
        end else if (a == `OFS_TXBUF) begin
            v = s.txbuf;
        end else if (a == `OFS_RXBUF) begin
            v = s.rxbuf;
        end else if (a == `OFS_STATUS) begin
            v = {s.fe, s.ovr, s.brk_err, s.brk_ok, 1'b0, s.rx_valid,
                 s.txbuf_full, s.tx_st != serial_pkg::TX_IDLE};
        end else if (a == `OFS_ROUTE) begin
            v = {6'h00, s.route};
        end
        return v;
    endfunction

    // Next transmit bit and shifted register, per bit order
    function automatic logic [8:0] tx_next(input logic [7:0] sh,
                                           input logic msb);
        return msb ? {sh[7], sh[6:0], 1'b0} : {sh[0], 1'b0, sh[7:1]};
    endfunction

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_i = rst_sync_q[1];

    assign acc = hsel & htrans[1] & hready;
    assign last_bit = st_q.mode[`MODE_LEN8] ? 5'h07 : 5'h06; // see R1
    assign brk_last = `BRK_BASE_BITS - 5'h01
        + {2'h0, st_q.ctrl[`CTRL_BRK_LEN_HI:`CTRL_BRK_LEN_LO]}; // see R7
    assign tx_bit_end = st_q.tx_tick == st_q.baud; // see R3
    assign rx_full_end = st_q.rx_tick == st_q.baud;

    always_comb begin
        st_d = st_q;
        st_d.tx_done = 1'b0;
        st_d.rx_done = 1'b0;
        st_d.brk_pulse = 1'b0;
        st_d.wr_pend = acc & hwrite;
        // Three-stage input; a level counts once the last two agree
        st_d.rx_sync = {st_q.rx_sync[1:0], serial_rx_pin};
        if (st_q.rx_sync[1] == st_q.rx_sync[2]) begin
            st_d.rx_filt = st_q.rx_sync[2];
        end
        if (acc) begin
            st_d.addr = haddr[7:0];
        end
        if (acc && !hwrite) begin
            st_d.rdata = {24'h000000, rd_mux(st_q, haddr[7:0])};
            if (haddr[7:0] == `OFS_RXBUF) begin
                st_d.rx_valid = 1'b0;
            end
        end
        if (st_q.wr_pend) begin
            if (st_q.addr == `OFS_MODE) begin
                st_d.mode = hwdata[7:0];
            end else if (st_q.addr == `OFS_CTRL) begin
                st_d.ctrl = hwdata[7:0] & 8'h3F;
                if (hwdata[`CTRL_BRK_SEND]) begin
                    st_d.ctrl[`CTRL_BRK_SEND] = 1'b1;
                end
                st_d.ctrl[`CTRL_BRK_ARM] = st_q.ctrl[`CTRL_BRK_ARM]
                    | hwdata[`CTRL_BRK_ARM];
                if (hwdata[`CTRL_BRK_ARM]) begin
                    st_d.rx_sh = `RST_BUF; // see R9
                end
            end else if (st_q.addr == `OFS_BAUD) begin
                st_d.baud = hwdata[7:0];
            end else if (st_q.addr == `OFS_CLKSEL) begin
                st_d.clksel = hwdata[2:0];
            end else if (st_q.addr == `OFS_TXBUF) begin
                st_d.txbuf = hwdata[7:0]; // see R24
                st_d.txbuf_full = 1'b1;
            end else if (st_q.addr == `OFS_STATUS) begin
                // Write one to clear; a same-cycle hardware set wins below
                if (hwdata[`ST_BRK_OK]) st_d.brk_ok = 1'b0;
                if (hwdata[`ST_BRK_ERR]) st_d.brk_err = 1'b0;
                if (hwdata[`ST_OVERRUN]) st_d.ovr = 1'b0;
                if (hwdata[`ST_FRAMING]) st_d.fe = 1'b0;
            end else if (st_q.addr == `OFS_ROUTE) begin
                st_d.route = hwdata[1:0];
            end
        end
        // Base clock: power-of-two prescale feeding the bit divider
        st_d.pre_cnt = st_q.pre_cnt + 8'h01;
        st_d.base_tick = ((st_q.pre_cnt & ((8'h01 << st_q.clksel) - 8'h01))
            == ((8'h01 << st_q.clksel) - 8'h01)); // see R2
        if (st_q.base_tick) begin
            st_d.tx_en_s = st_q.mode[`MODE_TXEN]; // see R13
            st_d.rx_en_s = st_q.mode[`MODE_RXEN];
        end
        // Transmitter, stepped by the base clock (see R4)
        if (st_q.base_tick && st_q.tx_en_s) begin
            st_d.tx_tick = tx_bit_end ? 8'h00 : st_q.tx_tick + 8'h01;
            case (st_q.tx_st)
                serial_pkg::TX_IDLE: begin
                    st_d.tx_tick = 8'h00;
                    st_d.tx_bits = 5'h00;
                    if (st_q.ctrl[`CTRL_BRK_SEND]) begin
                        st_d.ctrl[`CTRL_BRK_SEND] = 1'b0;
                        st_d.tx_st = serial_pkg::TX_BREAK; // see R7
                        st_d.tx_line = 1'b0;
                    end else if (st_q.txbuf_full) begin
                        st_d.tx_sh = st_q.txbuf;
                        st_d.txbuf_full = 1'b0;
                        st_d.tx_st = serial_pkg::TX_START; // see R26
                        st_d.tx_line = 1'b0;
                    end
                end
                serial_pkg::TX_BREAK: begin
                    if (tx_bit_end) begin
                        st_d.tx_bits = st_q.tx_bits + 5'h01;
                        if (st_q.tx_bits == brk_last) begin
                            st_d.tx_st = serial_pkg::TX_STOP;
                            st_d.tx_line = 1'b1;
                        end
                    end
                end
                serial_pkg::TX_START, serial_pkg::TX_DATA: begin
                    if (tx_bit_end) begin
                        if (st_q.tx_st == serial_pkg::TX_START) begin
                            st_d.tx_st = serial_pkg::TX_DATA;
                            st_d.tx_bits = 5'h00;
                        end else begin
                            st_d.tx_bits = st_q.tx_bits + 5'h01;
                        end
                        if (st_q.tx_st == serial_pkg::TX_DATA &&
                            st_q.tx_bits == last_bit) begin
                            st_d.tx_st = serial_pkg::TX_STOP;
                            st_d.tx_line = 1'b1;
                        end else begin
                            // see R5
                            {st_d.tx_line, st_d.tx_sh} = tx_next(st_q.tx_sh,
                                st_q.ctrl[`CTRL_MSB_FIRST]);
                        end
                    end
                end
                serial_pkg::TX_STOP: begin
                    if (tx_bit_end) begin
                        st_d.tx_done = 1'b1; // see R10
                        st_d.tx_tick = 8'h00;
                        st_d.tx_st = st_q.txbuf_full ? serial_pkg::TX_GAP
                            : serial_pkg::TX_IDLE;
                    end
                end
                serial_pkg::TX_GAP: begin
                    // Idle then spends the second tick before the start bit
                    if (st_q.tx_tick == `GAP_TICKS - 8'h02) begin
                        st_d.tx_st = serial_pkg::TX_IDLE; // see R15
                    end
                end
                default: st_d.tx_st = serial_pkg::TX_IDLE;
            endcase
        end
        // Receiver, stepped by the base clock
        if (st_q.base_tick && st_q.rx_en_s) begin
            st_d.rx_tick = st_q.rx_tick + 8'h01;
            case (st_q.rx_st)
                serial_pkg::RX_IDLE: begin
                    st_d.rx_tick = 8'h00;
                    if (!st_q.rx_filt) begin
                        st_d.rx_st = serial_pkg::RX_START; // see R26
                    end
                end
                serial_pkg::RX_START: begin
                    if (st_q.rx_tick == {1'b0, st_q.baud[7:1]}) begin
                        st_d.rx_tick = 8'h00;
                        st_d.rx_bits = 5'h00;
                        st_d.rx_st = st_q.rx_filt ? serial_pkg::RX_IDLE
                            : serial_pkg::RX_DATA;
                    end
                end
                serial_pkg::RX_DATA: begin
                    if (rx_full_end) begin
                        st_d.rx_tick = 8'h00;
                        if (st_q.ctrl[`CTRL_BRK_ARM]) begin
                            // Low samples counted; start bit adds one
                            if (!st_q.rx_filt) begin
                                if (st_q.rx_bits != 5'h1F) begin
                                    st_d.rx_bits = st_q.rx_bits + 5'h01;
                                end
                            end else begin
                                st_d.rx_st = serial_pkg::RX_IDLE;
                                if (st_q.rx_bits
                                    >= `BRK_VALID_BITS - 5'h01) begin
                                    st_d.brk_pulse = 1'b1; // see R8
                                    st_d.brk_ok = 1'b1;
                                    st_d.ctrl[`CTRL_BRK_ARM] = 1'b0;
                                end else begin
                                    st_d.brk_err = 1'b1; // see R8
                                end
                            end
                        end else begin
                            st_d.rx_bits = st_q.rx_bits + 5'h01;
                            st_d.rx_sh = st_q.ctrl[`CTRL_MSB_FIRST]
                                ? {st_q.rx_sh[6:0], st_q.rx_filt}
                                : {st_q.rx_filt, st_q.rx_sh[7:1]}; // see R5
                            if (st_q.rx_bits == last_bit) begin
                                st_d.rx_st = serial_pkg::RX_STOP;
                            end
                        end
                    end
                end
                serial_pkg::RX_STOP: begin
                    if (rx_full_end) begin
                        st_d.rx_st = serial_pkg::RX_IDLE;
                        st_d.rx_done = 1'b1;
                        if (!st_q.rx_filt) begin
                            st_d.fe = 1'b1;
                        end
                        if (st_q.rx_valid) begin
                            st_d.ovr = 1'b1; // see R23
                        end else begin
                            st_d.rx_valid = 1'b1;
                            if (st_q.mode[`MODE_LEN8]) begin
                                st_d.rxbuf = st_q.rx_sh;
                            end else if (st_q.ctrl[`CTRL_MSB_FIRST]) begin
                                st_d.rxbuf = {st_q.rx_sh[6:0], 1'b0}; // see R22
                            end else begin
                                st_d.rxbuf = {1'b0, st_q.rx_sh[7:1]}; // see R22
                            end
                        end
                    end
                end
                default: st_d.rx_st = serial_pkg::RX_IDLE;
            endcase
        end
        // A disabled path returns to idle with the line high
        if (!st_q.tx_en_s) begin
            st_d.tx_st = serial_pkg::TX_IDLE;
            st_d.tx_line = 1'b1;
        end
        if (!st_q.rx_en_s) begin
            st_d.rx_st = serial_pkg::RX_IDLE;
        end
        if (!st_q.mode[`MODE_POWER]) begin
            st_d.pre_cnt = 8'h00; // see R25
            st_d.base_tick = 1'b0;
            st_d.tx_en_s = 1'b0;
            st_d.rx_en_s = 1'b0;
            st_d.tx_st = serial_pkg::TX_IDLE;
            st_d.rx_st = serial_pkg::RX_IDLE;
            st_d.tx_line = 1'b1;
            st_d.txbuf_full = 1'b0;
            st_d.rx_valid = 1'b0;
            st_d.ovr = 1'b0;
            st_d.fe = 1'b0;
            st_d.brk_ok = 1'b0;
            st_d.brk_err = 1'b0;
        end
        st_d.tx_pin = st_d.tx_line ^ st_d.ctrl[`CTRL_TX_INV]; // see R6
        if (clock_stop) begin
            st_d = st_q; // see R11
        end
    end

    always_ff @(posedge clk or negedge rst_i) begin
        if (!rst_i) begin
            st_q <= '0;
            st_q.mode <= `RST_MODE;
            st_q.baud <= `RST_BAUD;
            st_q.txbuf <= `RST_BUF;
            st_q.rxbuf <= `RST_BUF;
            st_q.rx_sh <= `RST_BUF;
            st_q.rx_sync <= 3'h7;
            st_q.rx_filt <= 1'b1;
            st_q.tx_line <= 1'b1;
            st_q.tx_pin <= 1'b1;
            st_q.tx_st <= serial_pkg::TX_IDLE;
            st_q.rx_st <= serial_pkg::RX_IDLE;
        end else begin
            st_q <= st_d;
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = st_q.rdata;
    assign serial_tx_pin = st_q.tx_pin;
    assign tx_done_interrupt = st_q.tx_done;
    assign rx_done_interrupt = st_q.rx_done;
    assign break_interrupt = st_q.brk_pulse;
    assign external_edge_interrupt = st_q.route[`ROUTE_IRQ]
        ? st_q.rx_filt : 1'b1; // see R21
    assign timer_capture_input = st_q.route[`ROUTE_TIMER]
        ? st_q.rx_filt : 1'b1; // see R21

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_i);

    sequence s_break_begin;
        st_q.tx_st == serial_pkg::TX_IDLE ##1
        st_q.tx_st == serial_pkg::TX_BREAK;
    endsequence

    a_break_starts_low: assert property (s_break_begin |->
        !st_q.tx_line && st_q.tx_bits == 5'h00) // see R7
        else $error("break did not start low");
    a_done_after_stop: assert property (st_q.tx_done |->
        $past(st_q.tx_st) == serial_pkg::TX_STOP) // see R10
        else $error("tx done without stop bit");
    a_tx_pin_invert: assert property (serial_tx_pin ==
        (st_q.tx_line ^ st_q.ctrl[`CTRL_TX_INV])) // see R6
        else $error("tx pin polarity wrong");
    a_break_valid_len: assert property (st_q.brk_pulse |->
        $past(st_q.rx_bits) >= `BRK_VALID_BITS - 5'h01) // see R8
        else $error("break accepted too short");
    a_break_no_load: assert property (st_q.ctrl[`CTRL_BRK_ARM] |->
        st_q.rx_st != serial_pkg::RX_STOP && st_q.rx_sh == `RST_BUF) // see R9
        else $error("data path active in break mode");
    a_overrun_keeps_buf: assert property ($rose(st_q.ovr) && !clock_stop
        |-> $stable(st_q.rxbuf)) // see R23
        else $error("overrun changed buffer");
    a_seven_bit_place: assert property ($rose(st_q.rx_valid) &&
        !st_q.mode[`MODE_LEN8] |-> (st_q.ctrl[`CTRL_MSB_FIRST]
        ? !st_q.rxbuf[0] : !st_q.rxbuf[7])) // see R22
        else $error("seven-bit placement wrong");
    a_power_off_idle: assert property (!st_q.mode[`MODE_POWER] && !clock_stop
        |=> st_q.tx_st == serial_pkg::TX_IDLE && !st_q.base_tick) // see R25
        else $error("logic running with power off");
    a_freeze_hold: assert property (clock_stop |=> $stable(st_q)) // see R11
        else $error("state moved while clock stopped");
    a_enable_sync: assert property ($rose(st_q.tx_en_s) |->
        $past(st_q.base_tick)) // see R13
        else $error("enable not taken on base tick");

endmodule // lin_capable_async_serial

// ---- serial_node.sv ----
// Behavioural remote serial node: frame decoder and frame sender
`timescale 1ns/1ps

module serial_node #(
    parameter int BIT_NS = 40
) (
    // Serial lines
    input wire logic line_in,
    output logic line_out
);
    logic [7:0] got = 8'hFF;
    initial line_out = 1'b1;
    // Re-arms on the first falling edge after each frame, so a break only leaves junk in got
    always begin : decode
        @(negedge line_in);
        #(BIT_NS / 2);
        for (int i = 0; i < 8; i++) begin
            #(BIT_NS);
            got[i] = line_in;
        end
        #(BIT_NS);
    end
    // A low run of low_bits bits; data bits follow only for a plain frame
    task automatic send(input logic [7:0] d, input int low_bits);
        #1; // Keeps every line change off the sampling edge
        line_out = 1'b0;
        #(BIT_NS * low_bits);
        for (int i = 0; i < 8 && low_bits == 1; i++) begin
            line_out = d[i];
            #(BIT_NS);
        end
        line_out = 1'b1;
        #(BIT_NS * 2);
    endtask
endmodule // serial_node

// ---- lin_capable_async_serial_test.sv ----
// Register-level test of the serial unit against a remote node model
`timescale 1ns/1ps
`include "serial_defs.svh"

module lin_capable_async_serial_test;
    localparam int BIT_CLKS = 8;
    localparam int CLK_NS = 5;
    logic clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic clock_stop = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    wire [2:0] ev;
    logic hreadyout, hresp, serial_rx_pin, serial_tx_pin, ext_irq, cap_in;
    int err_total = 0, total_checks = 0;
    time t0;
    always #2.5 clk = ~clk;
    lin_capable_async_serial u_lin_capable_async_serial (
        .clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .clock_stop(clock_stop),
        .serial_rx_pin(serial_rx_pin), .serial_tx_pin(serial_tx_pin),
        .tx_done_interrupt(ev[0]), .rx_done_interrupt(ev[1]),
        .break_interrupt(ev[2]), .external_edge_interrupt(ext_irq),
        .timer_capture_input(cap_in)
    );
    serial_node #(.BIT_NS(BIT_CLKS * CLK_NS)) u_serial_node (
        .line_in(serial_tx_pin), .line_out(serial_rx_pin)
    );
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Leading edge wait keeps one idle cycle between any two transfers
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        xfer(1'b1, a, {24'h0, d});
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        xfer(1'b0, a, 32'h0);
        chk(r, {24'h0, e});
    endtask
    task automatic wait_ev(input int sel, input logic exp);
        logic got;
        got = 1'b0;
        for (int n = 0; n < 2000 && !got; n++) begin
            @(posedge clk);
            #1;
            got = (ev[sel] === 1'b1);
        end
        chk({31'h0, got}, {31'h0, exp});
    endtask
    task automatic end_of_test;
        $display("Checks %0d, mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        #200000;
        err_total++;
        end_of_test();
    end
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        rd(`OFS_MODE, `RST_MODE);
        rd(`OFS_BAUD, `RST_BAUD);
        rd(`OFS_TXBUF, `RST_BUF);
        rd(`OFS_RXBUF, `RST_BUF);
        rd(8'h20, 8'h00);
        chk({30'h0, hreadyout, hresp}, 32'h2);
        wr(`OFS_CLKSEL, 8'h00);
        wr(`OFS_BAUD, 8'(BIT_CLKS - 1));
        wr(`OFS_MODE, 8'h84);
        wr(`OFS_MODE, 8'hE4);
        repeat (4) @(posedge clk);
        fork
            begin
                wr(`OFS_TXBUF, 8'hA5);
                wait_ev(0, 1'b1);
            end
            u_serial_node.send(8'h3C, 1);
            wait_ev(1, 1'b1);
        join
        chk(u_serial_node.got, 8'hA5);
        rd(`OFS_RXBUF, 8'h3C);
        u_serial_node.send(8'h55, 1);
        u_serial_node.send(8'h66, 1);
        rd(`OFS_RXBUF, 8'h55);
        rd(`OFS_STATUS, 8'h40);
        wr(`OFS_MODE, 8'hE0);
        wr(`OFS_CTRL, 8'h02);
        fork
            u_serial_node.send(8'hF1, 1);
            wait_ev(1, 1'b1);
        join
        rd(`OFS_RXBUF, 8'h8E);
        fork
            wr(`OFS_TXBUF, 8'hB4);
            wait_ev(0, 1'b1);
        join
        chk(u_serial_node.got, 8'hAD);
        wr(`OFS_CTRL, 8'h01);
        repeat (4) @(posedge clk);
        chk({31'h0, serial_tx_pin}, 32'h0);
        wr(`OFS_ROUTE, 8'h03);
        wr(`OFS_STATUS, 8'hFF);
        wr(`OFS_CTRL, 8'h80);
        fork
            u_serial_node.send(8'h00, 10);
            wait_ev(2, 1'b0);
            wait_ev(1, 1'b0);
        join
        rd(`OFS_STATUS, 8'h20);
        fork
            u_serial_node.send(8'h00, 12);
            wait_ev(2, 1'b1);
            begin
                repeat (40) @(posedge clk);
                chk({30'h0, ext_irq, cap_in}, 32'h0);
            end
        join
        rd(`OFS_STATUS, 8'h30);
        rd(`OFS_RXBUF, 8'h8E);
        wr(`OFS_MODE, 8'h80);
        wr(`OFS_BAUD, 8'(BIT_CLKS - 1));
        wr(`OFS_MODE, 8'hE4);
        wr(`OFS_CTRL, 8'h80);
        rd(`OFS_CTRL, 8'h80);
        // Base clock halved for the 13-bit break, full rate for 20 bits
        for (int l = 0; l < 8; l += 7) begin
            wr(`OFS_CLKSEL, 8'(1 - l / 7));
            wr(`OFS_CTRL, 8'h40 | 8'(l << 2));
            @(negedge serial_tx_pin);
            t0 = $time;
            @(posedge serial_tx_pin);
            chk(32'(($time - t0) / CLK_NS),
                32'((13 + l) * BIT_CLKS * (2 - l / 7)));
            wait_ev(0, 1'b1);
        end
        wr(`OFS_TXBUF, 8'h80);
        wait_ev(0, 1'b1);
        chk(u_serial_node.got, 8'h80);
        repeat (40) @(posedge clk);
        wr(`OFS_CTRL, 8'h00);
        wr(`OFS_TXBUF, 8'h0F);
        @(negedge serial_tx_pin);
        repeat (12) @(posedge clk);
        clock_stop <= 1'b1;
        repeat (40) @(posedge clk);
        chk({31'h0, serial_tx_pin}, 32'h1);
        clock_stop <= 1'b0;
        wr(`OFS_MODE, 8'h04);
        rd(`OFS_STATUS, 8'h00);
        repeat (100) @(posedge clk);
        end_of_test();
    end
endmodule // lin_capable_async_serial_test
